// File: core/fec_ctrl.sv
// Notes on behaviour
// - Mass, segment and global bits decode together into the erase kind.
// - Global plus mass erases every array, information too if segment bit set.
// - Erase select bits clear on emergency exit or when erase finishes.
// - Reserved bits read zero and ignore writes.
// - Keyed registers (erase, clock, status, margin): upper byte reads 96h; writes need A5h, else power-up clear.
// - Clock select 00 auxiliary, 01 master, 10 and 11 sub-main clock.
// - Divider field divides the selected clock by value plus one.
// - Failure flag sets on clock failure or interrupt abort; software clears.
// - Writing one toggles segment-A protect; writing zero leaves it.
// - Segment-A protect spares segment A and information memory on mass erase.
// - Lock blocks write and erase; a running operation still finishes.
// - Lock during block write with wait set ends block write cleanly.
// - Wait reads one when ready for the next write, zero otherwise.
// - Access violation flag reads one while its interrupt is pending.
// - Shared enable bit gates the access violation interrupt request.
// - Wrong key sets key violation flag and power-up clear; software clears.
// - Busy reads one while the timing generator runs an operation.
// - Margin-one bit selects marginal-one reads.
// - Margin-zero selects marginal-zero reads; margin-one wins when both set.
// - Margin bits clear when the processor starts executing from flash.
// - Emergency exit clears block-write and write mode bits.
// - Erase control write during erase or write sets the violation flag.
// - Violation flag holds until cleared and feeds the non-maskable path.
`include "fec_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module fec_ctrl
    import fec_pkg::*;
(
    // Clock and reset.
    input  wire logic        mclk,
    input  wire logic        rst,
    // AHB-Lite slave.
    input  wire logic        hsel,
    input  wire logic [11:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Clock sources and system events.
    input  wire logic        aux_clk_tick,
    input  wire logic        master_clk_tick,
    input  wire logic        sub_main_clock_tick,
    input  wire logic        clk_src_fail,
    input  wire logic        irq_abort,
    input  wire logic        cpu_fetch_flash,
    // Flash array side.
    output logic             ftg_tick,
    output logic             erase_busy,
    output logic             program_busy,
    output fec_erase_t       erase_kind,
    output logic             spare_info,
    output fec_read_t        read_mode,
    // System outputs.
    output logic             power_up_clear,
    output logic             nmi_req
);

    // Bus address phase capture.
    logic        wr_pend_ff;
    logic        rd_pend_ff;
    logic [11:0] addr_ff;
    logic        req;
    assign req = hsel & hready & htrans[1];

    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_pend_ff <= 1'b0;
            rd_pend_ff <= 1'b0;
            addr_ff    <= 12'h000;
        end else begin
            wr_pend_ff <= req & hwrite;
            rd_pend_ff <= req & ~hwrite;
            addr_ff    <= haddr;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Data phase write decode.
    wire key_ok   = (hwdata[15:8] == `FEC_KEY_WRITE);
    wire hit_er   = (addr_ff == `FEC_OFS_ERASE);
    wire hit_clk  = (addr_ff == `FEC_OFS_CLOCK);
    wire hit_st   = (addr_ff == `FEC_OFS_STATUS);
    wire hit_mrg  = (addr_ff == `FEC_OFS_MARGIN);
    wire hit_ie   = (addr_ff == `FEC_OFS_ENABLE);
    wire hit_cmd  = (addr_ff == `FEC_OFS_OPCMD);
    wire hit_key  = hit_er | hit_clk | hit_st | hit_mrg;
    wire bad_key  = wr_pend_ff & hit_key & ~key_ok;
    wire good_wr  = wr_pend_ff & key_ok;
    wire wr_er    = good_wr & hit_er;
    wire wr_clk   = good_wr & hit_clk;
    wire wr_st    = good_wr & hit_st;
    wire wr_mrg   = good_wr & hit_mrg;
    wire wr_ie    = wr_pend_ff & hit_ie;
    wire wr_cmd   = wr_pend_ff & hit_cmd;

    // Register state.
    logic       blkwr_ff, wrmode_ff, exiten_ff, gmass_ff, mass_ff, seg_ff;
    logic [7:0] clkcfg_ff;
    logic       fail_ff, sega_ff, emergency_exit_ff, lock_ff, accv_ff, key_violation_flag_ff;
    logic       margin_one_enable_ff, margin_zero_enable_ff, accie_ff;
    fec_state_t state_ff;
    logic [7:0] op_cnt_ff;
    logic [5:0] div_cnt_ff;
    logic       op_erase_ff;

    wire busy     = (state_ff == FEC_RUN);
    wire wait_rdy = (state_ff != FEC_RUN);
    wire blk_wait = (state_ff == FEC_BLKWAIT);

    // Erase control writes are refused while an erase or a write, single or block, is running.
    wire er_viol  = wr_er & busy & ~(blkwr_ff & wait_rdy);
    wire clk_viol = wr_clk & busy;

    // Selected flash clock and divider.
    logic src_tick;
    always_comb begin
        case (clkcfg_ff[7:6])
            2'b00:   src_tick = aux_clk_tick;
            2'b01:   src_tick = master_clk_tick;
            default: src_tick = sub_main_clock_tick;
        endcase
    end

    // Divide by field plus one.
    wire div_wrap = src_tick & (div_cnt_ff == clkcfg_ff[5:0]);
    always_ff @(posedge mclk) begin
        if (rst) begin
            div_cnt_ff <= 6'h00;
        end else if (div_wrap) begin
            div_cnt_ff <= 6'h00;
        end else if (src_tick) begin
            div_cnt_ff <= div_cnt_ff + 6'h01;
        end
    end
    assign ftg_tick = div_wrap;

    // Operation start from the command register, gated by lock.
    wire start_ok = wr_cmd & ~lock_ff & ~emergency_exit_ff;
    wire start_er = start_ok & ~busy & ~blk_wait & (mass_ff | seg_ff);
    wire start_wr = start_ok & (state_ff != FEC_RUN) & wrmode_ff & ~(mass_ff | seg_ff);
    wire op_done  = busy & ftg_tick & (op_cnt_ff == `FEC_OP_TICKS);
    wire aborted  = busy & ((irq_abort & exiten_ff) | clk_src_fail);
    wire blk_end  = blk_wait & lock_ff & blkwr_ff;

    // Timing generator state machine.
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff    <= FEC_IDLE;
            op_cnt_ff   <= 8'h00;
            op_erase_ff <= 1'b0;
        end else begin
            case (state_ff)
                FEC_IDLE: begin
                    op_cnt_ff <= 8'h00;
                    if (start_er | start_wr) begin
                        state_ff    <= FEC_RUN;
                        op_erase_ff <= start_er;
                    end
                end
                FEC_RUN: begin
                    if (emergency_exit_ff | aborted) begin
                        state_ff <= FEC_IDLE;
                    end else if (op_done) begin
                        state_ff <= (blkwr_ff & ~op_erase_ff) ? FEC_BLKWAIT : FEC_IDLE;
                    end else if (ftg_tick) begin
                        op_cnt_ff <= op_cnt_ff + 8'h01;
                    end
                end
                default: begin
                    op_cnt_ff <= 8'h00;
                    if (emergency_exit_ff | blk_end | ~blkwr_ff) begin
                        state_ff <= FEC_IDLE;
                    end else if (start_wr) begin
                        state_ff    <= FEC_RUN;
                        op_erase_ff <= 1'b0;
                    end
                end
            endcase
        end
    end

    // Erase control register.
    wire er_clr = emergency_exit_ff | (op_done & op_erase_ff);
    always_ff @(posedge mclk) begin
        if (rst) begin
            blkwr_ff  <= 1'b0;
            wrmode_ff <= 1'b0;
            exiten_ff <= 1'b0;
            gmass_ff  <= 1'b0;
            mass_ff   <= 1'b0;
            seg_ff    <= 1'b0;
        end else if (emergency_exit_ff) begin
            blkwr_ff  <= 1'b0;
            wrmode_ff <= 1'b0;
            exiten_ff <= 1'b0;
            gmass_ff  <= 1'b0;
            mass_ff   <= 1'b0;
            seg_ff    <= 1'b0;
        end else if (wr_er & ~er_viol) begin
            blkwr_ff  <= hwdata[`FEC_B_BLKWR];
            wrmode_ff <= hwdata[`FEC_B_WRMODE];
            exiten_ff <= hwdata[`FEC_B_EXITEN];
            gmass_ff  <= hwdata[`FEC_B_GMASS];
            mass_ff   <= hwdata[`FEC_B_MASS];
            seg_ff    <= hwdata[`FEC_B_SEG];
        end else begin
            if (blk_end) begin
                blkwr_ff <= 1'b0;
            end
            if (er_clr) begin
                gmass_ff <= 1'b0;
                mass_ff  <= 1'b0;
                seg_ff   <= 1'b0;
            end
        end
    end

    // Clock config register; refused while busy.
    always_ff @(posedge mclk) begin
        if (rst) begin
            clkcfg_ff <= `FEC_RST_CLOCK;
        end else if (wr_clk & ~busy) begin
            clkcfg_ff <= hwdata[7:0];
        end
    end

    // Status and lock register; hardware sets win over software clears.
    always_ff @(posedge mclk) begin
        if (rst) begin
            fail_ff <= 1'b0;
            sega_ff <= `FEC_RST_SEGA;
            emergency_exit_ff <= 1'b0;
            lock_ff <= `FEC_RST_LOCK;
            accv_ff <= 1'b0;
            key_violation_flag_ff <= 1'b0;
        end else begin
            fail_ff <= clk_src_fail | aborted | (wr_st ? hwdata[`FEC_B_FAIL] & fail_ff : fail_ff);
            if (wr_st & hwdata[`FEC_B_SEGA]) begin
                sega_ff <= ~sega_ff;
            end
            if (wr_st) begin
                emergency_exit_ff <= hwdata[`FEC_B_EMERGENCY_EXIT];
                lock_ff <= hwdata[`FEC_B_LOCK];
            end
            accv_ff <= er_viol | clk_viol | (wr_st ? hwdata[`FEC_B_ACCV] & accv_ff : accv_ff);
            key_violation_flag_ff <= bad_key | (wr_st ? hwdata[`FEC_B_KEY_VIOLATION_FLAG] & key_violation_flag_ff : key_violation_flag_ff);
        end
    end

    // Margin read register and shared enable bit.
    always_ff @(posedge mclk) begin
        if (rst) begin
            margin_one_enable_ff  <= 1'b0;
            margin_zero_enable_ff  <= 1'b0;
            accie_ff <= 1'b0;
        end else begin
            if (cpu_fetch_flash) begin
                margin_one_enable_ff <= 1'b0;
                margin_zero_enable_ff <= 1'b0;
            end else if (wr_mrg) begin
                margin_one_enable_ff <= hwdata[`FEC_B_MARGIN_ONE_ENABLE];
                margin_zero_enable_ff <= hwdata[`FEC_B_MARGIN_ZERO_ENABLE];
            end
            if (wr_ie) begin
                accie_ff <= hwdata[`FEC_B_ACCIE];
            end
        end
    end

    // Read mode: margin one wins over margin zero.
    assign read_mode = margin_one_enable_ff ? FEC_RD_MARGIN1 :
                       margin_zero_enable_ff ? FEC_RD_MARGIN0 : FEC_RD_NORMAL;

    // Erase kind decode.
    function automatic fec_erase_t erase_decode(input logic g, input logic m, input logic s);
        if (!m && !s) begin
            erase_decode = FEC_ER_NONE;
        end else if (!m) begin
            erase_decode = FEC_ER_SEGMENT;
        end else if (!g) begin
            erase_decode = s ? FEC_ER_MAIN_INFO_SEL : FEC_ER_MAIN_SEL;
        end else begin
            erase_decode = s ? FEC_ER_MAIN_INFO_ALL : FEC_ER_MAIN_ALL;
        end
    endfunction
    assign erase_kind   = erase_decode(gmass_ff, mass_ff, seg_ff);
    assign spare_info   = sega_ff & mass_ff;
    assign erase_busy   = busy & op_erase_ff;
    assign program_busy = busy & ~op_erase_ff;

    // Power-up clear request and non-maskable interrupt.
    logic puc_ff;
    always_ff @(posedge mclk) begin
        if (rst) begin
            puc_ff <= 1'b0;
        end else begin
            puc_ff <= bad_key;
        end
    end
    assign power_up_clear = puc_ff;
    assign nmi_req        = accv_ff & accie_ff;

    // Read data mux; reserved bits stay zero.
    wire [7:0] er_rd = {blkwr_ff, wrmode_ff, 1'b0, exiten_ff, gmass_ff, mass_ff, seg_ff, 1'b0};
    wire [7:0] st_rd = {fail_ff, sega_ff, emergency_exit_ff, lock_ff, wait_rdy, accv_ff, key_violation_flag_ff, busy};
    wire [7:0] mg_rd = {2'b00, margin_one_enable_ff, margin_zero_enable_ff, 4'h0};
    wire [15:0] rd_mux = hit_er  ? {`FEC_KEY_READ, er_rd} :
                         hit_clk ? {`FEC_KEY_READ, clkcfg_ff} :
                         hit_st  ? {`FEC_KEY_READ, st_rd} :
                         hit_mrg ? {`FEC_KEY_READ, mg_rd} :
                         hit_ie  ? {8'h00, 2'b00, accie_ff, 5'h00} : 16'h0000;
    assign hrdata = rd_pend_ff ? {16'h0000, rd_mux} : 32'h0000_0000;

    // Checks.
    a_key_violation_flag_sets: assert property (@(posedge mclk) disable iff (rst)
        bad_key |=> key_violation_flag_ff && power_up_clear) else $error("key violation missed");
    a_erase_clears: assert property (@(posedge mclk) disable iff (rst)
        (emergency_exit_ff && !wr_pend_ff) |=> !mass_ff && !seg_ff && !gmass_ff) else $error("erase bits stuck");
    a_margin_prio: assert property (@(posedge mclk) disable iff (rst)
        margin_one_enable_ff |-> read_mode == FEC_RD_MARGIN1) else $error("margin priority");
    a_accv_hold: assert property (@(posedge mclk) disable iff (rst)
        (accv_ff && !wr_st) |=> accv_ff) else $error("violation flag dropped");
    a_fetch_clear: assert property (@(posedge mclk) disable iff (rst)
        cpu_fetch_flash |=> !margin_one_enable_ff && !margin_zero_enable_ff) else $error("margin not cleared");
    a_lock_start: assert property (@(posedge mclk) disable iff (rst)
        (lock_ff && state_ff == FEC_IDLE) |=> state_ff == FEC_IDLE) else $error("started while locked");
    a_sega_toggle: assert property (@(posedge mclk) disable iff (rst)
        (wr_st && hwdata[`FEC_B_SEGA]) |=> sega_ff != $past(sega_ff)) else $error("protect no toggle");
    a_er_viol: assert property (@(posedge mclk) disable iff (rst)
        er_viol |=> accv_ff) else $error("violation not flagged");
    a_fail_set: assert property (@(posedge mclk) disable iff (rst)
        clk_src_fail |=> fail_ff) else $error("fail not set");

    // Read data checks: the key byte, the upper half and the reserved bits.
    a_key_read: assert property (@(posedge mclk) disable iff (rst)
        (rd_pend_ff && hit_key) |-> hrdata[15:8] == `FEC_KEY_READ) else $error("key byte wrong");
    a_upper_zero: assert property (@(posedge mclk) disable iff (rst)
        rd_pend_ff |-> hrdata[31:16] == 16'h0000) else $error("upper half not zero");
    a_rsvd_zero: assert property (@(posedge mclk) disable iff (rst)
        (rd_pend_ff && hit_er) |-> !hrdata[5] && !hrdata[0]) else $error("reserved bit set");

    // Operation control checks.
    a_blk_end: assert property (@(posedge mclk) disable iff (rst)
        blk_end |=> state_ff == FEC_IDLE && !blkwr_ff) else $error("block write not ended");
    a_emergency_exit_stop: assert property (@(posedge mclk) disable iff (rst)
        (emergency_exit_ff && busy) |=> !busy) else $error("exit did not stop");
    a_fail_abort: assert property (@(posedge mclk) disable iff (rst)
        aborted |=> fail_ff) else $error("abort not flagged");
    a_clk_refuse: assert property (@(posedge mclk) disable iff (rst)
        clk_viol |=> accv_ff && clkcfg_ff == $past(clkcfg_ff)) else $error("clock write not refused");
    a_er_refuse: assert property (@(posedge mclk) disable iff (rst)
        (er_viol && !emergency_exit_ff && !op_done) |=> mass_ff == $past(mass_ff) && seg_ff == $past(seg_ff))
        else $error("erase write not refused");
    a_kind_none: assert property (@(posedge mclk) disable iff (rst)
        (!mass_ff && !seg_ff) |-> erase_kind == FEC_ER_NONE) else $error("erase kind not none");
    a_margin_zero: assert property (@(posedge mclk) disable iff (rst)
        (margin_zero_enable_ff && !margin_one_enable_ff) |-> read_mode == FEC_RD_MARGIN0) else $error("margin zero missed");
    a_div_tick: assert property (@(posedge mclk) disable iff (rst)
        (ftg_tick && clkcfg_ff[5:0] != 6'h00 && !wr_clk) |=> !ftg_tick) else $error("tick too soon");

endmodule // fec_ctrl

`default_nettype wire

// File: core/fec_cfg.svh
`ifndef FEC_CFG_SVH
`define FEC_CFG_SVH

// Word byte offsets of the registers on the bus.
`define FEC_OFS_ERASE  12'h000
`define FEC_OFS_CLOCK  12'h004
`define FEC_OFS_STATUS 12'h008
`define FEC_OFS_MARGIN 12'h00C
`define FEC_OFS_ENABLE 12'h010
`define FEC_OFS_OPCMD  12'h014

// Key byte values.
`define FEC_KEY_READ  8'h96
`define FEC_KEY_WRITE 8'hA5

// Erase control field positions.
`define FEC_B_BLKWR  7
`define FEC_B_WRMODE 6
`define FEC_B_EXITEN 4
`define FEC_B_GMASS  3
`define FEC_B_MASS   2
`define FEC_B_SEG    1

// Status and lock field positions.
`define FEC_B_FAIL  7
`define FEC_B_SEGA  6
`define FEC_B_EMERGENCY_EXIT  5
`define FEC_B_LOCK  4
`define FEC_B_WAIT  3
`define FEC_B_ACCV  2
`define FEC_B_KEY_VIOLATION_FLAG  1
`define FEC_B_BUSY  0

// Margin and enable field positions.
`define FEC_B_MARGIN_ONE_ENABLE  5
`define FEC_B_MARGIN_ZERO_ENABLE  4
`define FEC_B_ACCIE 5

// Reset values of the low bytes.
`define FEC_RST_CLOCK 8'h42
`define FEC_RST_SEGA  1'b1
`define FEC_RST_LOCK  1'b1

// Last tick count of one erase or write operation; the operation lasts this value plus one divided flash clock ticks.
`define FEC_OP_TICKS 8'h0F

`endif

// File: core/fec_pkg.sv
package fec_pkg;
    typedef enum logic [1:0] {
        FEC_IDLE,
        FEC_RUN,
        FEC_BLKWAIT
    } fec_state_t;

    typedef enum logic [2:0] {
        FEC_ER_NONE,
        FEC_ER_SEGMENT,
        FEC_ER_MAIN_SEL,
        FEC_ER_MAIN_INFO_SEL,
        FEC_ER_MAIN_ALL,
        FEC_ER_MAIN_INFO_ALL
    } fec_erase_t;

    typedef enum logic [1:0] {
        FEC_RD_NORMAL,
        FEC_RD_MARGIN0,
        FEC_RD_MARGIN1
    } fec_read_t;
endpackage

// File: verif/fec_far_model.sv
`timescale 1ns/1ns
`default_nettype none

module fec_far_model (
    // Clock and reset.
    input  wire logic mclk,
    input  wire logic rst,
    // Failure command from the bench.
    input  wire logic fail_cmd,
    // Source pulses and failure level.
    output logic      aux_clk_tick,
    output logic      master_clk_tick,
    output logic      sub_main_clock_tick,
    output logic      clk_src_fail
);
    logic [2:0] aux_ff;
    logic [1:0] sub_ff;

    // Auxiliary ticks every 7th cycle, sub-main every 3rd; failure shows only when commanded.
    always_ff @(posedge mclk) begin
        aux_ff       <= (rst || aux_ff == 3'h6) ? 3'h0 : aux_ff + 3'h1;
        sub_ff       <= (rst || sub_ff == 2'h2) ? 2'h0 : sub_ff + 2'h1;
        clk_src_fail <= fail_cmd && !rst;
    end

    // The master clock is the bus clock, so its enable stays on.
    assign master_clk_tick     = 1'b1;
    assign aux_clk_tick        = (aux_ff == 3'h6);
    assign sub_main_clock_tick = (sub_ff == 2'h2);
endmodule // fec_far_model

`default_nettype wire

// File: verif/fec_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "fec_cfg.svh"

module fec_ctrl_tb
    import fec_pkg::*;
;
    localparam logic [11:0] er  = `FEC_OFS_ERASE;
    localparam logic [11:0] ck  = `FEC_OFS_CLOCK;
    localparam logic [11:0] st  = `FEC_OFS_STATUS;
    localparam logic [11:0] mg  = `FEC_OFS_MARGIN;
    localparam logic [11:0] en  = `FEC_OFS_ENABLE;
    localparam logic [11:0] op  = `FEC_OFS_OPCMD;
    localparam logic [31:0] all = 32'hFFFF_FFFF;

    // Bus, event and observed signals.
    logic        mclk, rst, hsel, hwrite, hreadyout, hresp;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata;
    logic        aux_clk_tick, master_clk_tick, sub_main_clock_tick, clk_src_fail;
    logic        fail_cmd, irq_abort, cpu_fetch_flash;
    logic        ftg_tick, erase_busy, program_busy, spare_info, power_up_clear, nmi_req;
    fec_erase_t  erase_kind;
    fec_read_t   read_mode;
    int          fails, n_compared;
    int          cyc = 0;

    fec_ctrl dut (
        .mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
        .hreadyout, .hresp, .aux_clk_tick, .master_clk_tick, .sub_main_clock_tick, .clk_src_fail,
        .irq_abort, .cpu_fetch_flash, .ftg_tick, .erase_busy, .program_busy, .erase_kind, .spare_info,
        .read_mode, .power_up_clear, .nmi_req
    );

    fec_far_model far (
        .mclk, .rst, .fail_cmd, .aux_clk_tick, .master_clk_tick, .sub_main_clock_tick, .clk_src_fail
    );

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // One single word transfer; the address phase is held until hready is seen high.
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        q = hrdata;
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, a, {16'h0000, d}, q);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        cmp($sformatf("reg %h", a), e, q & m);
    endtask

    task automatic go(input logic [15:0] e);
        wr(er, e);
        wr(op, 16'h0000);
    endtask

    // Pulse one event input: 0 flash fetch, 1 interrupt abort, 2 source failure.
    task automatic pulse(input int w);
        @(posedge mclk);
        {fail_cmd, irq_abort, cpu_fetch_flash} <= 3'h1 << w;
        @(posedge mclk);
        {fail_cmd, irq_abort, cpu_fetch_flash} <= 3'h0;
        repeat (2) @(posedge mclk);
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        while ((erase_busy | program_busy) !== 1'b0 && n < 3000) begin
            @(posedge mclk);
            n++;
        end
        cmp("busy", 1'b0, erase_busy | program_busy);
    endtask

    task automatic t_reset;
        logic [31:0] q;
        rd(er, all, 32'h0000_9600);
        rd(ck, all, 32'h0000_9642);
        rd(st, all, 32'h0000_9658);
        rd(mg, all, 32'h0000_9600);
        rd(en, 32'h0000_0020, 32'h0000_0000);
        bus(1'b0, 12'h01C, 32'h0000_0000, q);
        cmp("hresp", 1'b0, hresp);
        cmp("nmi", 1'b0, nmi_req);
        $display("reset test done");
    endtask

    task automatic t_key;
        logic [2:0] n;
        wr(er, 16'h5A02);
        n = 3'h0;
        repeat (4) begin
            @(posedge mclk);
            n = n + {2'h0, power_up_clear};
        end
        cmp("puc pulses", 3'h1, n);
        rd(er, all, 32'h0000_9600);
        rd(st, all, 32'h0000_965A);
        wr(st, 16'hA510);
        rd(st, all, 32'h0000_9658);
        $display("key test done");
    endtask

    task automatic t_erase;
        logic [2:0] s [7] = '{3'h0, 3'h1, 3'h5, 3'h2, 3'h3, 3'h6, 3'h7};
        fec_erase_t k [7] = '{FEC_ER_NONE, FEC_ER_SEGMENT, FEC_ER_SEGMENT, FEC_ER_MAIN_SEL,
                              FEC_ER_MAIN_INFO_SEL, FEC_ER_MAIN_ALL, FEC_ER_MAIN_INFO_ALL};
        for (int i = 0; i < 7; i++) begin
            wr(er, {8'hA5, 4'h0, s[i], 1'b0});
            cmp("erase kind", k[i], erase_kind);
        end
        wr(er, 16'hA5FF);
        rd(er, all, 32'h0000_96DE);
        wr(st, 16'hA530);
        rd(er, all, 32'h0000_9600);
        wr(st, 16'hA510);
        $display("erase test done");
    endtask

    task automatic t_margin;
        wr(mg, 16'hA5FF);
        rd(mg, all, 32'h0000_9630);
        cmp("read mode", FEC_RD_MARGIN1, read_mode);
        wr(mg, 16'hA510);
        cmp("read mode", FEC_RD_MARGIN0, read_mode);
        wr(mg, 16'hA520);
        cmp("read mode", FEC_RD_MARGIN1, read_mode);
        pulse(0);
        rd(mg, all, 32'h0000_9600);
        cmp("read mode", FEC_RD_NORMAL, read_mode);
        $display("margin test done");
    endtask

    task automatic t_sega;
        wr(ck, 16'hA540);
        wr(st, 16'hA540);
        rd(st, all, 32'h0000_9608);
        go(16'hA504);
        cmp("spare", 1'b0, spare_info);
        wait_idle;
        wr(st, 16'hA540);
        rd(st, 32'h0000_0040, 32'h0000_0040);
        go(16'hA504);
        cmp("spare", 1'b1, spare_info);
        wait_idle;
        $display("segment protect test done");
    endtask

    task automatic t_blk;
        go(16'hA5C0);
        repeat (24) @(posedge mclk);
        wr(st, 16'hA510);
        wait_idle;
        rd(er, all, 32'h0000_9640);
        go(16'hA502);
        repeat (2) @(posedge mclk);
        cmp("erase busy", 1'b0, erase_busy);
        wr(er, 16'hA500);
        $display("block write test done");
    endtask

    task automatic t_clk;
        logic [7:0] cf [5] = '{8'h02, 8'h42, 8'h82, 8'hC2, 8'h7F};
        int pr [5] = '{21, 3, 9, 9, 64};
        int n;
        for (int i = 0; i < 5; i++) begin
            wr(ck, {8'hA5, cf[i]});
            rd(ck, all, {16'h0000, 8'h96, cf[i]});
            wr(st, 16'hA500);
            go(16'hA502);
            rd(st, 32'h0000_0009, 32'h0000_0001);
            repeat (2) begin
                n = 0;
                do begin
                    @(posedge mclk);
                    n++;
                end while (ftg_tick !== 1'b1 && n < 3000);
            end
            cmp("tick gap", pr[i], n);
            wait_idle;
            rd(er, all, 32'h0000_9600);
        end
        $display("clock test done");
    endtask

    task automatic t_viol;
        logic [31:0] q;
        bus(1'b0, en, 32'h0000_0000, q);
        wr(en, {8'h00, q[7:0] | 8'h20});
        go(16'hA502);
        wr(er, 16'hA504);
        wr(ck, 16'hA542);
        wr(st, 16'hA514);
        cmp("nmi", 1'b1, nmi_req);
        rd(ck, all, 32'h0000_967F);
        rd(st, 32'h0000_0017, 32'h0000_0015);
        wait_idle;
        rd(er, all, 32'h0000_9600);
        bus(1'b0, en, 32'h0000_0000, q);
        wr(en, {8'h00, q[7:0] & 8'hDF});
        cmp("nmi", 1'b0, nmi_req);
        rd(st, 32'h0000_0004, 32'h0000_0004);
        wr(st, 16'hA510);
        rd(st, all, 32'h0000_9658);
        $display("violation test done");
    endtask

    task automatic t_fail;
        pulse(2);
        rd(st, 32'h0000_0080, 32'h0000_0080);
        wr(st, 16'hA510);
        rd(st, 32'h0000_0080, 32'h0000_0000);
        wr(st, 16'hA500);
        go(16'hA512);
        pulse(1);
        wait_idle;
        rd(st, 32'h0000_0080, 32'h0000_0080);
        $display("failure test done");
    endtask

    // Clock of 50 ns period.
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // Reset for 12 cycles, then each scenario in turn.
    initial begin
        {rst, hsel, hwrite, fail_cmd, irq_abort, cpu_fetch_flash} = 6'h20;
        {haddr, htrans, hsize, hwdata} = {12'h000, 2'h0, 3'h2, 32'h0000_0000};
        fails = 0;
        n_compared = 0;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_reset;
        t_key;
        t_erase;
        t_margin;
        t_sega;
        t_blk;
        t_clk;
        t_viol;
        t_fail;
        finish_test;
    end

    // Cut a hang short well beyond the expected run length.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 12000) begin
            fails++;
            finish_test;
        end
    end
endmodule // fec_ctrl_tb

`default_nettype wire
